// ==== rtl/tcw_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tcw_cfg.svh"
module tcw_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // compare output pins
  output logic COMPARE_OUT_A,
  output logic COMPARE_OE_A,
  output logic COMPARE_OUT_B,
  output logic COMPARE_OE_B,
  // interrupt
  output logic IRQ
);
  tcw_pkg::tcw_state_t r_reg;
  tcw_pkg::tcw_state_t r_next;
  tcw_pkg::tcw_wave_t wave;
  tcw_pkg::tcw_evt_t evt [2];
  logic [1:0] com [2];
  logic [1:0] lvl;
  logic [7:0] cmp_act [2];
  logic [7:0] top_val;
  logic run;
  logic wgm_hi;
  logic at_top;
  logic at_bottom;
  logic ovf;
  logic [2:0] hits;
  logic [2:0] clr;
  logic take;

  // three-bit mode to waveform class
  function automatic tcw_pkg::tcw_wave_t wave_of(input logic [2:0] m);
    case (m)
      3'h0: wave_of = tcw_pkg::TCW_NORMAL;
      3'h2: wave_of = tcw_pkg::TCW_CLEAR;
      3'h3, 3'h7: wave_of = tcw_pkg::TCW_FAST;
      3'h1, 3'h5: wave_of = tcw_pkg::TCW_PHASE;
      default: wave_of = tcw_pkg::TCW_RSVD;
    endcase
  endfunction

  function automatic logic [31:0] read_mux(input tcw_pkg::tcw_state_t s, input logic [7:0] a);
    case (a)
      `TCW_OFF_CTRL_A: read_mux = {24'h000000, s.ctrl_a};
      `TCW_OFF_CTRL_B: read_mux = {24'h000000, s.ctrl_b};
      `TCW_OFF_COUNT: read_mux = {24'h000000, s.cnt};
      `TCW_OFF_CMP_A: read_mux = {24'h000000, s.cmp_a_buf};
      `TCW_OFF_CMP_B: read_mux = {24'h000000, s.cmp_b_buf};
      `TCW_OFF_STATUS: read_mux = {29'h00000000, s.stat};
      `TCW_OFF_MASK: read_mux = {29'h00000000, s.mask};
      `TCW_OFF_PIN_DIR: read_mux = {30'h00000000, s.dir_en};
      default: read_mux = 32'h00000000;
    endcase
  endfunction

  assign run = r_reg.ctrl_b[`TCW_RUN_BIT];
  assign wgm_hi = r_reg.ctrl_b[`TCW_WGM_TOP_BIT];
  assign wave = wave_of({wgm_hi, r_reg.ctrl_a[`TCW_WGM_HI:`TCW_WGM_LO]});
  assign com[0] = r_reg.ctrl_a[`TCW_COM_A_HI:`TCW_COM_A_LO];
  assign com[1] = r_reg.ctrl_a[`TCW_COM_B_HI:`TCW_COM_B_LO];
  assign cmp_act[0] = r_reg.cmp_a;
  assign cmp_act[1] = r_reg.cmp_b;
  // top from compare A in clear-on-match and in modes 5 and 7
  assign top_val = (wave == tcw_pkg::TCW_CLEAR || wgm_hi) ? r_reg.cmp_a : `TCW_MAX;
  assign at_top = (r_reg.cnt == top_val);
  assign at_bottom = (r_reg.cnt == `TCW_BOTTOM);
  assign take = HSEL & HTRANS[1] & HREADY;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      assign evt[gi].match = run & (r_reg.cnt == cmp_act[gi]);
      assign evt[gi].bottom = run & at_bottom;
      assign evt[gi].top = run & at_top;
      assign evt[gi].up = r_reg.up;
      assign evt[gi].cmp_top = (cmp_act[gi] == top_val);
      tcw_cmp_out #(.CHAN_B(gi == 1)) u_out (
        .clk(CLK),
        .rst_n(RST_N),
        .com(com[gi]),
        .wgm_hi(wgm_hi),
        .wave(wave),
        .evt(evt[gi]),
        .lvl(lvl[gi])
      );
    end
  endgenerate

  always_comb begin
    r_next = r_reg;
    ovf = 1'b0;
    clr = 3'h0;
    // register writes land in the data phase
    if (r_reg.wr_pend) begin
      case (r_reg.waddr)
        `TCW_OFF_CTRL_A: r_next.ctrl_a = HWDATA[7:0] & `TCW_CTRL_A_MASK;
        `TCW_OFF_CTRL_B: r_next.ctrl_b = HWDATA[7:0] & `TCW_CTRL_B_MASK;
        `TCW_OFF_CMP_A: r_next.cmp_a_buf = HWDATA[7:0];
        `TCW_OFF_CMP_B: r_next.cmp_b_buf = HWDATA[7:0];
        `TCW_OFF_STATUS: clr = HWDATA[2:0];
        `TCW_OFF_MASK: r_next.mask = HWDATA[2:0];
        `TCW_OFF_PIN_DIR: r_next.dir_en = HWDATA[1:0];
        default: r_next.mask = r_reg.mask;
      endcase
    end
    // counting sequence per waveform class
    if (run) begin
      case (wave)
        tcw_pkg::TCW_NORMAL: begin
          r_next.cnt = r_reg.cnt + 8'h01;
          ovf = (r_reg.cnt == `TCW_MAX);
        end
        tcw_pkg::TCW_CLEAR: begin
          r_next.cnt = at_top ? `TCW_BOTTOM : r_reg.cnt + 8'h01;
          ovf = (r_reg.cnt == `TCW_MAX);
        end
        tcw_pkg::TCW_FAST: begin
          r_next.cnt = at_top ? `TCW_BOTTOM : r_reg.cnt + 8'h01;
          ovf = at_top;
          // reload on the wrap so new values start at bottom
          if (at_top) begin
            r_next.cmp_a = r_reg.cmp_a_buf;
            r_next.cmp_b = r_reg.cmp_b_buf;
          end
        end
        tcw_pkg::TCW_PHASE: begin
          if (r_reg.up) begin
            if (at_top) begin
              r_next.up = 1'b0;
              r_next.cnt = at_bottom ? r_reg.cnt : r_reg.cnt - 8'h01;
              r_next.cmp_a = r_reg.cmp_a_buf;
              r_next.cmp_b = r_reg.cmp_b_buf;
            end else begin
              r_next.cnt = r_reg.cnt + 8'h01;
            end
          end else if (at_bottom) begin
            r_next.up = 1'b1;
            r_next.cnt = r_reg.cnt + 8'h01;
            ovf = 1'b1;
          end else begin
            r_next.cnt = r_reg.cnt - 8'h01;
          end
        end
        default: r_next.cnt = r_reg.cnt;
      endcase
    end
    if (wave != tcw_pkg::TCW_PHASE) begin
      r_next.up = 1'b1;
    end
    // normal and clear-on-match classes use compare values immediately
    if (wave == tcw_pkg::TCW_NORMAL || wave == tcw_pkg::TCW_CLEAR) begin
      r_next.cmp_a = r_next.cmp_a_buf;
      r_next.cmp_b = r_next.cmp_b_buf;
    end
    hits = 3'h0;
    hits[`TCW_ST_OVF] = ovf;
    hits[`TCW_ST_MATCH_A] = evt[0].match;
    hits[`TCW_ST_MATCH_B] = evt[1].match;
    // a hit in the clearing cycle survives
    r_next.stat = (r_reg.stat & ~clr) | hits;
    r_next.irq = |(r_next.stat & r_next.mask);
    // pin driven only when mode is nonzero and software set direction
    r_next.oe[0] = (r_next.ctrl_a[`TCW_COM_A_HI:`TCW_COM_A_LO] != 2'b00) & r_next.dir_en[0];
    r_next.oe[1] = (r_next.ctrl_a[`TCW_COM_B_HI:`TCW_COM_B_LO] != 2'b00) & r_next.dir_en[1];
    // address phase; read data built from post-write state
    r_next.wr_pend = take & HWRITE;
    if (take) begin
      r_next.waddr = {HADDR[7:2], 2'b00};
    end
    if (take && !HWRITE) begin
      r_next.rdata = read_mux(r_next, {HADDR[7:2], 2'b00});
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign HRDATA = r_reg.rdata;
  // zero wait states, never an error
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign COMPARE_OUT_A = lvl[0];
  assign COMPARE_OUT_B = lvl[1];
  assign COMPARE_OE_A = r_reg.oe[0];
  assign COMPARE_OE_B = r_reg.oe[1];
  assign IRQ = r_reg.irq;
endmodule // tcw_top
`default_nettype wire

// ==== rtl/tcw_cfg.svh ====
// Function
// - Channel A output mode sits in control bits 7:6, and any nonzero value hands the pin over to compare_out_a; the code also needs dir_en bit 0.
// - Channel B output mode sits in control bits 5:4, and any nonzero value hands the pin over to compare_out_b; the code also needs dir_en bit 1.
// - In normal or clear-on-match mode, channel A codes 00/01/10/11 mean disconnect/toggle/clear/set on match.
// - In normal or clear-on-match mode, channel B codes 00/01/10/11 mean disconnect/toggle/clear/set on match.
// - In fast PWM, A code 01 toggles on match only with waveform_mode_hi, 10 clears/sets at BOTTOM, 11 inverts.
// - In fast PWM, channel B code 01 is reserved, 10 clears on match and sets at BOTTOM, 11 does the inverse.
// - Phase-correct A: 10 clears on up match, sets on down match, 11 reverse, 01 toggles with waveform_mode_hi.
// - In phase-correct PWM, channel B code 01 is reserved, 10 clears up and sets down, 11 the reverse.
// - In fast PWM, a compare value equal to TOP with the upper mode bit set ignores the match and acts at BOTTOM.
// - In phase-correct PWM, a compare value equal to TOP with upper mode bit set ignores the match, acts at TOP.
// - The waveform mode is control bits 1:0 plus waveform_mode_hi and picks sequence, TOP source and waveform.
// - Modes 0 and 2 use TOP 0xFF and compare_value_a, update compare values at once and flag overflow at MAX.
// - 1/5 phase-correct: load at TOP, flag at BOTTOM; 3/7 fast: load at BOTTOM, flag at MAX/TOP; 4/6 reserved.
`ifndef TCW_CFG_SVH
`define TCW_CFG_SVH
`define TCW_OFF_CTRL_A 8'h00
`define TCW_OFF_CTRL_B 8'h04
`define TCW_OFF_COUNT 8'h08
`define TCW_OFF_CMP_A 8'h0c
`define TCW_OFF_CMP_B 8'h10
`define TCW_OFF_STATUS 8'h14
`define TCW_OFF_MASK 8'h18
`define TCW_OFF_PIN_DIR 8'h1c
`define TCW_COM_A_HI 7
`define TCW_COM_A_LO 6
`define TCW_COM_B_HI 5
`define TCW_COM_B_LO 4
`define TCW_WGM_HI 1
`define TCW_WGM_LO 0
`define TCW_WGM_TOP_BIT 3
`define TCW_RUN_BIT 0
`define TCW_CTRL_A_MASK 8'hf3
`define TCW_CTRL_B_MASK 8'h09
`define TCW_ST_OVF 0
`define TCW_ST_MATCH_A 1
`define TCW_ST_MATCH_B 2
`define TCW_RST_BYTE 8'h00
`define TCW_RST_FLAGS 3'h0
`define TCW_MAX 8'hff
`define TCW_BOTTOM 8'h00
`endif

// ==== rtl/tcw_pkg.sv ====
`default_nettype none
package tcw_pkg;
  typedef enum logic [4:0] {
    TCW_NORMAL = 5'b00001,
    TCW_CLEAR = 5'b00010,
    TCW_FAST = 5'b00100,
    TCW_PHASE = 5'b01000,
    TCW_RSVD = 5'b10000
  } tcw_wave_t;

  typedef struct packed {
    logic match;
    logic bottom;
    logic top;
    logic up;
    logic cmp_top;
  } tcw_evt_t;

  typedef struct packed {
    logic lvl;
  } tcw_pin_t;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] cnt;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [1:0] dir_en;
    logic up;
    logic [1:0] oe;
    logic irq;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] waddr;
  } tcw_state_t;
endpackage
`default_nettype wire

// ==== rtl/tcw_cmp_out.sv ====
`timescale 1ns/10ps
`default_nettype none
module tcw_cmp_out #(
  parameter bit CHAN_B = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration
  input wire logic [1:0] com,
  input wire logic wgm_hi,
  input wire tcw_pkg::tcw_wave_t wave,
  // counter events
  input wire tcw_pkg::tcw_evt_t evt,
  // waveform
  output logic lvl
);
  tcw_pkg::tcw_pin_t r_reg;
  tcw_pkg::tcw_pin_t r_next;
  logic ign;
  logic tgl;

  always_comb begin
    r_next = r_reg;
    ign = com[1] & evt.cmp_top;
    // code 01 toggles in PWM only on channel A with the TOP-select bit
    tgl = (com == 2'b01) & ~CHAN_B & wgm_hi & evt.match;
    case (wave)
      tcw_pkg::TCW_NORMAL, tcw_pkg::TCW_CLEAR: begin
        if (evt.match) begin
          case (com)
            2'b01: r_next.lvl = ~r_reg.lvl;
            2'b10: r_next.lvl = 1'b0;
            2'b11: r_next.lvl = 1'b1;
            default: r_next.lvl = r_reg.lvl;
          endcase
        end
      end
      tcw_pkg::TCW_FAST: begin
        if (tgl) begin
          r_next.lvl = ~r_reg.lvl;
        end
        if (com[1]) begin
          if (evt.bottom) begin
            r_next.lvl = ~com[0];
          end
          // match wins over bottom so a zero compare still shows
          if (evt.match && !ign) begin
            r_next.lvl = com[0];
          end
        end
      end
      tcw_pkg::TCW_PHASE: begin
        if (tgl) begin
          r_next.lvl = ~r_reg.lvl;
        end
        if (com[1]) begin
          if (evt.match && !ign) begin
            r_next.lvl = evt.up ? com[0] : ~com[0];
          end
          if (ign && evt.top) begin
            r_next.lvl = com[0];
          end
        end
      end
      default: r_next.lvl = r_reg.lvl;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign lvl = r_reg.lvl;
endmodule // tcw_cmp_out
`default_nettype wire

// ==== tb/tcw_top_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module tcw_top_assertions (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  // pins
  input wire logic COMPARE_OUT_A,
  input wire logic COMPARE_OE_A,
  input wire logic COMPARE_OUT_B,
  input wire logic COMPARE_OE_B
);
  logic wp;
  logic [7:0] wa, sa, sb, sd, pa, pb, pd;
  // settled config only, so one cycle of pin lag stays legal
  wire st = {pa, pb, pd} == {sa, sb, sd};
  wire hi = sb[3];
  wire npwm = !sa[0] && !hi;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      {wp, wa, sa, sb, sd, pa, pb, pd} <= '0;
    end else begin
      wp <= HSEL && HTRANS[1] && HREADY && HWRITE;
      wa <= HADDR[7:0];
      {pa, pb, pd} <= {sa, sb, sd};
      if (wp && wa == 8'h00) sa <= HWDATA[7:0];
      if (wp && wa == 8'h04) sb <= HWDATA[7:0];
      if (wp && wa == 8'h1c) sd <= HWDATA[7:0];
    end
  end
  a_oe_a_map: assert property (st |-> COMPARE_OE_A == ((|sa[7:6]) && sd[0]))
    else $error("pin a enable wrong");
  a_oe_b_map: assert property (st |-> COMPARE_OE_B == ((|sa[5:4]) && sd[1]))
    else $error("pin b enable wrong");
  a_a_set_hold: assert property (st && npwm && sa[7:6] == 2'h3 |-> !$fell(COMPARE_OUT_A))
    else $error("pin a fell in set code");
  a_a_clr_hold: assert property (st && npwm && sa[7:6] == 2'h2 |-> !$rose(COMPARE_OUT_A))
    else $error("pin a rose in clear code");
  a_b_set_hold: assert property (st && npwm && sa[5:4] == 2'h3 |-> !$fell(COMPARE_OUT_B))
    else $error("pin b fell in set code");
  a_a_fast_off: assert property (st && sa[1:0] == 2'h3 && !hi && sa[7:6] == 2'h1 |-> $stable(COMPARE_OUT_A))
    else $error("pin a moved while off");
  a_b_pwm_rsvd: assert property (st && sa[0] && sa[5:4] == 2'h1 |-> $stable(COMPARE_OUT_B))
    else $error("pin b moved in reserved code");
  a_rsvd_frozen: assert property (st && hi && !sa[0] |-> $stable({COMPARE_OUT_A, COMPARE_OUT_B}))
    else $error("pins moved in reserved mode");
endmodule // tcw_top_assertions
bind tcw_top tcw_top_assertions tcw_top_assertions_i (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .COMPARE_OUT_A(COMPARE_OUT_A),
  .COMPARE_OE_A(COMPARE_OE_A), .COMPARE_OUT_B(COMPARE_OUT_B), .COMPARE_OE_B(COMPARE_OE_B));
`default_nettype wire

// ==== tb/tcw_load.sv ====
`timescale 1ns/10ps
`default_nettype none
module tcw_load (
  // clock
  input wire logic clk,
  // pin drive, bit 0 is channel a
  input wire logic [1:0] lvl,
  input wire logic [1:0] oe,
  // what the load sees
  output logic [1:0] pin,
  output logic [1:0][15:0] rises,
  output logic [1:0][15:0] falls,
  output logic [1:0][15:0] hlen
);
  int run[2] = '{0, 0};
  logic [1:0] prev = 2'h0;
  // undriven pin sinks to its pull-down
  assign pin = oe & lvl;
  initial begin
    rises = '0;
    falls = '0;
    hlen = '0;
  end
  // nonblocking so the bench never races the counts at an edge
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (pin[i] && !prev[i]) rises[i] <= rises[i] + 16'h1;
      if (pin[i] && !prev[i]) run[i] = 0;
      if (!pin[i] && prev[i]) falls[i] <= falls[i] + 16'h1;
      if (!pin[i] && prev[i]) hlen[i] <= 16'(run[i]);
      if (pin[i]) run[i]++;
    end
    prev = pin;
  end
endmodule // tcw_load
`default_nettype wire

// ==== tb/test_timer_compare_waveform_modes.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_timer_compare_waveform_modes;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hrdy, hresp, irq;
  logic [31:0] hrdata, r, q;
  logic [1:0] out, oe, pin;
  logic [1:0][15:0] rises, falls, hlen;
  int n_fail = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  tcw_top tcw_top_i (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
    .COMPARE_OUT_A(out[0]), .COMPARE_OE_A(oe[0]), .COMPARE_OUT_B(out[1]), .COMPARE_OE_B(oe[1]), .IRQ(irq));
  tcw_load tcw_load_i (.clk(clk), .lvl(out), .oe(oe), .pin(pin), .rises(rises), .falls(falls), .hlen(hlen));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // wait states tolerated: both phases wait on ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task automatic t_regs();
    bus(1'b0, 8'h00, 32'h0);
    chk(r, 32'h0);
    bus(1'b1, 8'h00, 32'hff);
    bus(1'b0, 8'h00, 32'h0);
    chk(r, 32'hf3);
    bus(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    bus(1'b1, 8'h1c, 32'h3);
    bus(1'b1, 8'h00, 32'h40);
    repeat (2) @(posedge clk);
    chk({30'h0, oe}, 32'h1);
    bus(1'b1, 8'h00, 32'h10);
    repeat (2) @(posedge clk);
    chk({30'h0, oe}, 32'h2);
  endtask
  task automatic t_normal();
    bus(1'b1, 8'h0c, 32'h5);
    bus(1'b1, 8'h00, 32'h40);
    bus(1'b1, 8'h04, 32'h1);
    repeat (300) @(posedge clk);
    bus(1'b1, 8'h04, 32'h0);
    chk(32'(hlen[0]), 32'h100);
    bus(1'b0, 8'h14, 32'h0);
    chk(r & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h18, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h14, 32'h7);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_ctc();
    bus(1'b1, 8'h0c, 32'h9);
    bus(1'b1, 8'h10, 32'h4);
    for (int c = 3; c > 0; c--) begin
      q = 32'(rises[0]);
      bus(1'b1, 8'h00, 32'((c << 6) | (c << 4) | 2));
      bus(1'b1, 8'h04, 32'h1);
      repeat (300) @(posedge clk);
      bus(1'b0, 8'h08, 32'h0);
      chk({31'h0, r[7:0] <= 8'h09}, 32'h1);
      bus(1'b1, 8'h04, 32'h0);
      if (c == 1) chk({31'h0, 32'(rises[0]) >= q + 10}, 32'h1);
      else chk({30'h0, pin}, c == 3 ? 32'h3 : 32'h0);
    end
  endtask
  task automatic t_fast();
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h0c, 32'h40);
    bus(1'b1, 8'h10, 32'h20);
    bus(1'b1, 8'h00, 32'hb3);
    bus(1'b1, 8'h04, 32'h1);
    repeat (600) @(posedge clk);
    chk(32'(hlen[0]), 32'h40);
    chk(32'(hlen[1]), 32'he0);
    bus(1'b1, 8'h0c, 32'hff);
    repeat (300) @(posedge clk);
    q = 32'(falls[0]);
    repeat (300) @(posedge clk);
    chk(32'(falls[0]) - q, 32'h0);
    chk({31'h0, pin[0]}, 32'h1);
    bus(1'b1, 8'h04, 32'h0);
  endtask
  task automatic t_phase();
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h0c, 32'h40);
    bus(1'b1, 8'h00, 32'h91);
    bus(1'b1, 8'h04, 32'h1);
    repeat (1200) @(posedge clk);
    chk(32'(hlen[0]), 32'h80);
    bus(1'b1, 8'h04, 32'h0);
  endtask
  // compare A as TOP: fast mode 7, then phase-correct mode 5
  task automatic t_topsel();
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h0c, 32'h10);
    bus(1'b1, 8'h10, 32'h8);
    bus(1'b1, 8'h00, 32'h63);
    bus(1'b1, 8'h04, 32'h9);
    repeat (600) @(posedge clk);
    chk(32'(hlen[0]), 32'h11);
    chk(32'(hlen[1]), 32'h8);
    bus(1'b1, 8'h00, 32'hb1);
    repeat (300) @(posedge clk);
    q = 32'(rises[0]);
    repeat (100) @(posedge clk);
    chk(32'(rises[0]) - q, 32'h0);
    chk({31'h0, pin[0]}, 32'h0);
    chk(32'(hlen[1]), 32'h10);
    bus(1'b1, 8'h04, 32'h0);
  endtask
  task automatic t_rsvd();
    bus(1'b1, 8'h00, 32'h53);
    bus(1'b1, 8'h04, 32'h1);
    repeat (20) @(posedge clk);
    bus(1'b1, 8'h00, 32'h50);
    bus(1'b1, 8'h04, 32'h9);
    bus(1'b0, 8'h08, 32'h0);
    q = r;
    repeat (20) @(posedge clk);
    bus(1'b0, 8'h08, 32'h0);
    chk(r, q);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_normal();
    t_ctc();
    t_fast();
    t_phase();
    t_topsel();
    t_rsvd();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
endmodule // test_timer_compare_waveform_modes
`default_nettype wire
